// File: dv/ctr_master.sv
// two-wire master model for the trim slave
// assumes the bench clock paces an 80 ns bit, lines pulled up
module ctr_master (
  input  wire  clk,
  input  wire  sdaBus,
  output logic scl = 1'b1,
  output logic sda = 1'b1
);
  timeunit 1ns;
  timeprecision 1ps;
  // programming hold, far shorter than the real program time
  localparam int PROG_TICKS = 200;
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  // half high, half low: 50 percent duty, 12.5 MHz
  task automatic bitx(input b, output r);
    tick(2); sda = b; tick(2); scl = 1'b1;
    tick(2); r = sdaBus; tick(2); scl = 1'b0;
  endtask
  task automatic start();
    tick(2); sda = 1'b1; tick(2); scl = 1'b1;
    tick(4); sda = 1'b0; tick(4); scl = 1'b0;
  endtask
  task automatic stop();
    tick(2); sda = 1'b0; tick(2); scl = 1'b1;
    tick(4); sda = 1'b1; tick(4);
  endtask
  // clock held low from the last ack to stop; the block does not time it
  task automatic progwait();
    tick(PROG_TICKS);
  endtask
  task automatic xfer(input [7:0] d, input ackIn, output [7:0] r,
                      output a);
    for (int i = 7; i >= 0; i--) bitx(d[i], r[i]);
    bitx(ackIn, a);
  endtask
endmodule

// File: dv/ctr_props.sv
// checker of pin and code behaviour of the trim slave
// assumes binding onto ctr_slave, single clock domain
module ctr_props (
  // clock and reset
  input wire       clk,
  input wire       resetn,
  // serial pins
  input wire       sclIn,
  input wire       sdaIn,
  input wire       sdaOut,
  input wire       sdaOen_n,
  // memory image and strap
  input wire [8:0] storedCode,
  input wire [1:0] nibbleIndex,
  input wire       selectBit,
  // memory write
  input wire       memWrite,
  input wire [1:0] memNibble,
  input wire [3:0] memData,
  // capacitor control
  input wire [8:0] liveCode,
  input wire [8:0] controlCode,
  input wire       persistentMode,
  input wire [8:0] capDac
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_sda_only_low: assert property (!sdaOen_n |-> !sdaOut)
    else $error("data pin driven high");
  a_dac_follows_mode: assert property ($past(resetn) |-> capDac ==
    ($past(persistentMode) ? $past(controlCode) : $past(liveCode)))
    else $error("capacitor code mismatch");
  a_live_sets_volatile: assert property ($changed(liveCode) |-> !persistentMode)
    else $error("live code write kept persistent mode");
  a_ctrl_from_stored: assert property ($changed(controlCode)
    |-> controlCode == $past(storedCode))
    else $error("control code not from stored code");
  a_modeset_keeps_live: assert property ($rose(persistentMode) |-> $stable(liveCode))
    else $error("mode switch altered live code");
  a_modeset_no_load: assert property ($rose(persistentMode) |-> $stable(controlCode))
    else $error("mode switch loaded control code");
  a_mem_one_pulse: assert property (memWrite |=> !memWrite)
    else $error("memory write longer than a cycle");
  a_sda_steady_high: assert property (sclIn [*4] |-> $stable(sdaOen_n))
    else $error("data changed while clock high");
endmodule
bind ctr_slave ctr_props chk (.*);

// File: dv/ctr_slave_tb.sv
// self-checking bench of the trim slave
// assumes ctr_master as far side, checker bound to the slave
module ctr_slave_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam [6:0] ADDR = 7'h2B;
  logic        clk = 1'b0, resetn = 1'b0;
  logic [8:0]  storedCode = 9'h000, prev, code;
  logic [1:0]  nibbleIndex = 2'h0, memNibble, gotNib;
  logic [3:0]  memData, gotDat;
  logic        mScl, mSda, memWrite, sdaOut, sdaOen_n, persistentMode, ack;
  logic [8:0]  liveCode, controlCode, capDac;
  logic [7:0]  r;
  logic [3:0]  nib;
  logic        selBit;
  logic [31:0] img;
  int          fails = 0, cmp_count = 0, seed = 32714;
  wire         sdaBus = mSda & (sdaOen_n | sdaOut);
  always #5 clk = ~clk;
  always @(posedge clk) if (memWrite) {gotNib, gotDat} <= {memNibble, memData};
  ctr_master m (.clk(clk), .sdaBus(sdaBus), .scl(mScl), .sda(mSda));
  ctr_slave #(.DEV_ADDR(ADDR)) dut (.clk(clk), .resetn(resetn),
    .sclIn(mScl), .sdaIn(sdaBus), .sdaOut(sdaOut), .sdaOen_n(sdaOen_n),
    .storedCode(storedCode), .nibbleIndex(nibbleIndex),
    .selectBit(selBit), .memWrite(memWrite), .memNibble(memNibble),
    .memData(memData), .liveCode(liveCode), .controlCode(controlCode),
    .persistentMode(persistentMode), .capDac(capDac));
  task automatic chk(input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %0t output got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_ack(input logic got, exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %0t ack bit got %b exp %b", $time, got, exp);
    end
  endtask
  task automatic chk_img(input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %0t read image got %h exp %h", $time, got,
               exp);
    end
  endtask
  task automatic wr(input [7:0] hi, lo);
    m.start(); m.xfer({ADDR, 1'b0}, 1'b1, r, ack);
    chk_ack(ack, 1'b0);
    m.xfer(hi, 1'b1, r, ack); chk_ack(ack, 1'b0);
    m.xfer(lo, 1'b1, r, ack); chk_ack(ack, 1'b0);
    if (hi[7] && hi[7:4] != 4'h9) m.progwait();
    m.stop(); m.tick(6);
  endtask
  task automatic rd();
    m.start(); m.xfer({ADDR, 1'b1}, 1'b1, r, ack);
    chk_ack(ack, 1'b0);
    for (int i = 0; i < 4; i++) begin
      m.xfer(8'hFF, i == 3, r, ack);
      img = {img[23:0], r};
    end
    m.stop(); m.tick(6);
  endtask
  function automatic [31:0] expRd(input md, input [8:0] lv);
    return {4'h8, md, nibbleIndex, lv, 4'h0, selBit, 2'h2, storedCode};
  endfunction
  // memory image after one nibble write
  function automatic [8:0] nvMerge(input [8:0] old, input [1:0] n,
                                   input [3:0] d);
    case (n)
      2'h0: nvMerge = {old[8:4], d};
      2'h1: nvMerge = {old[8], d, old[3:0]};
      default: nvMerge = {d[0], old[7:0]};
    endcase
  endfunction
  task complete_run;
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    storedCode = 9'($random(seed));
    nibbleIndex = 2'($random(seed));
    selBit = 1'($random(seed));
    repeat (10) @(negedge clk);
    resetn = 1'b1;
    m.tick(4);
    rd();
    chk_img(img, expRd(1'b1, 9'h000));
    chk(controlCode, storedCode);
    repeat (6) begin
      code = 9'($random(seed));
      wr(8'($random(seed)) & 8'h7E | code[8], code[7:0]);
      chk(liveCode, code);
      chk({persistentMode, capDac}, {1'b0, code});
    end
    rd();
    chk_img(img, expRd(1'b0, code));
    prev = storedCode;
    storedCode = 9'($random(seed));
    wr(8'h90 | 8'($random(seed)) & 8'h0F, 8'($random(seed)));
    chk({persistentMode, liveCode}, {1'b1, code});
    chk({controlCode, capDac}, {prev, prev});
    rd(); chk({controlCode, capDac}, {storedCode, storedCode});
    chk_img(img, expRd(1'b1, code));
    for (int n = 0; n < 3; n++) begin
      nib = 4'($random(seed));
      wr({1'b1, 2'(n), 5'h00}, {4'h0, nib});
      chk({gotNib, gotDat}, {2'(n), nib});
      storedCode = nvMerge(storedCode, 2'(n), nib);
      nibbleIndex = 2'(n);
    end
    rd();
    chk_img(img, expRd(1'b1, code));
    chk({controlCode, capDac}, {storedCode, storedCode});
    m.start(); m.xfer({ADDR ^ 7'h40, 1'b0}, 1'b1, r, ack);
    chk_ack(ack, 1'b1);
    m.stop(); m.tick(6);
    complete_run();
  end
  initial begin
    #500000;
    fails++;
    complete_run();
  end
endmodule

// File: rtl/ctr_defines.vh
// constants for the capacitor trim serial slave
// assumes inclusion by the slave command logic file of the block
`ifndef CTR_DEFINES_VH
`define CTR_DEFINES_VH
`define CTR_READ_HI_NIB    4'h8
`define CTR_READ_B1_HI     4'h0
`define CTR_READ_B1_FIX    2'h2
`define CTR_MODESET_NIB    4'h9
`define CTR_CODE_RESET     9'h000
`define CTR_BIT_PERSIST    7
`define CTR_BIT_MODESET    4
`define CTR_READ_BYTES     3'h4
`define CTR_BYTE_BITS      4'h8
`define CTR_NIB_MSB        6
`define CTR_NIB_LSB        5
`define CTR_ADDR_DEFAULT   7'h2A
`endif

// File: rtl/ctr_slave.v
// two-wire slave command logic of the capacitor trim device
// assumes scl/sda arrive asynchronously; clk much faster than scl
// What this block does
// RULE_01 - address with read bit starts read
// RULE_02 - four read bytes, byte three first
// RULE_03 - byte three: 0x8, then mode flag
// RULE_04 - byte three: nibble index, live_code bit 8
// RULE_05 - byte two is live_code low bits
// RULE_06 - byte one: 0x0, select bit, 0x2, stored bit 8
// RULE_07 - byte zero is stored_code low bits
// RULE_08 - read copies stored code into control register
// RULE_09 - reads report most recently written codes
// RULE_10 - reset clears live_code to zero
// RULE_11 - high nibble 0x9 means switch to persistent
// RULE_12 - low command byte ignored for mode switch
// RULE_13 - persistent mode uses control register code
// RULE_14 - control register loads on read or reset
// RULE_15 - mode switch keeps live_code
// RULE_16 - master clock at most 400kHz; the bench master model runs 12.5 MHz
// RULE_17 - master allows program time before stop
// RULE_18 - high byte: persist, nibble index, mode bit
// RULE_19 - volatile write loads live_code, volatile mode
// RULE_20 - program interval from ack to stop
// RULE_21 - ack address; master nacks last read byte
// RULE_22 - ack command bytes, act after both
`include "ctr_defines.vh"
module ctr_slave #(
  parameter [6:0] DEV_ADDR = `CTR_ADDR_DEFAULT // arbitrary value
) (
  // clock and reset
  input  wire       clk,
  input  wire       resetn,
  // serial pins
  input  wire       sclIn,
  input  wire       sdaIn,
  output reg        sdaOut,
  output reg        sdaOen_n,
  // persistent memory image and strap
  input  wire [8:0] storedCode,
  input  wire [1:0] nibbleIndex,
  input  wire       selectBit,
  // persistent write request towards the memory
  output reg        memWrite,
  output reg  [1:0] memNibble,
  output reg  [3:0] memData,
  // capacitor control
  output reg  [8:0] liveCode,
  output reg  [8:0] controlCode,
  output reg        persistentMode,
  output reg  [8:0] capDac
);
  localparam ST_IDLE = 3'd0;
  localparam ST_ADDR = 3'd1;
  localparam ST_AACK = 3'd2;
  localparam ST_WBYT = 3'd3;
  localparam ST_WACK = 3'd4;
  localparam ST_RBYT = 3'd5;
  localparam ST_RACK = 3'd6;

  wire scl;
  wire sda;
  reg  sclQ;
  reg  sdaQ;
  reg  [2:0] state;
  reg  [3:0] bitCnt;
  reg  [7:0] shifter;
  reg  [7:0] cmdHi;
  reg        secondByte;
  reg  [2:0] bytesLeft;
  reg        started;

  ctr_sync syncScl (.clk(clk), .resetn(resetn), .async(sclIn), .sync(scl));
  ctr_sync syncSda (.clk(clk), .resetn(resetn), .async(sdaIn), .sync(sda));

  wire sclRise = scl & ~sclQ;
  wire sclFall = ~scl & sclQ;
  wire startCond = scl & sclQ & sdaQ & ~sda;
  wire stopCond  = scl & sclQ & ~sdaQ & sda;

  function [7:0] read_byte;
    input [2:0] idx;
    begin
      case (idx)
        3'd4: read_byte = {`CTR_READ_HI_NIB, persistentMode, // RULE_03
                           nibbleIndex, liveCode[8]};            // RULE_04
        3'd3: read_byte = liveCode[7:0];                          // RULE_05
        3'd2: read_byte = {`CTR_READ_B1_HI, selectBit,
                           `CTR_READ_B1_FIX, storedCode[8]};      // RULE_06
        default: read_byte = storedCode[7:0];                     // RULE_07
      endcase
    end
  endfunction

  // byte to put on the line at the next load
  wire [7:0] loadByte = read_byte(state == ST_AACK ? `CTR_READ_BYTES
                                                   : bytesLeft);

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sclQ <= 1'b1;
      sdaQ <= 1'b1;
      state <= ST_IDLE;
      bitCnt <= 4'h0;
      shifter <= 8'h00;
      cmdHi <= 8'h00;
      secondByte <= 1'b0;
      bytesLeft <= 3'h0;
      started <= 1'b0;
      sdaOut <= 1'b1;
      sdaOen_n <= 1'b1;
      memWrite <= 1'b0;
      memNibble <= 2'h0;
      memData <= 4'h0;
      liveCode <= `CTR_CODE_RESET;                                // RULE_10
      controlCode <= `CTR_CODE_RESET;
      persistentMode <= 1'b1;
      capDac <= `CTR_CODE_RESET;
    end else begin
      sclQ <= scl;
      sdaQ <= sda;
      memWrite <= 1'b0;
      // RULE_13 RULE_19
      capDac <= persistentMode ? controlCode : liveCode;
      // reload control register once after reset release
      if (!started) begin
        started <= 1'b1;
        controlCode <= storedCode;                                // RULE_14
      end
      if (startCond) begin
        state <= ST_ADDR;
        bitCnt <= 4'h0;
        sdaOen_n <= 1'b1;
      end else if (stopCond) begin
        state <= ST_IDLE;
        sdaOen_n <= 1'b1;
      end else begin
        case (state)
          ST_IDLE: begin
            sdaOen_n <= 1'b1;
          end
          ST_ADDR, ST_WBYT: begin
            if (sclRise) begin
              shifter <= {shifter[6:0], sda};
              bitCnt <= bitCnt + 4'h1;
            end else if (sclFall && bitCnt == `CTR_BYTE_BITS) begin
              bitCnt <= 4'h0;
              if (state == ST_ADDR) begin
                if (shifter[7:1] == DEV_ADDR) begin
                  state <= ST_AACK;
                  sdaOut <= 1'b0;
                  sdaOen_n <= 1'b0;                               // RULE_21
                end else begin
                  state <= ST_IDLE;
                end
              end else begin
                state <= ST_WACK;
                sdaOut <= 1'b0;
                sdaOen_n <= 1'b0;                                 // RULE_22
                if (!secondByte) begin
                  cmdHi <= shifter;
                end else if (cmdHi[7:4] == `CTR_MODESET_NIB) begin
                  persistentMode <= 1'b1;              // RULE_11 RULE_12 RULE_15
                end else if (cmdHi[`CTR_BIT_PERSIST]) begin
                  memWrite <= 1'b1;                               // RULE_18
                  memNibble <= cmdHi[`CTR_NIB_MSB:`CTR_NIB_LSB];
                  memData <= shifter[3:0];
                end else begin
                  liveCode <= {cmdHi[0], shifter};                // RULE_09
                  persistentMode <= 1'b0;                         // RULE_19
                end
                secondByte <= ~secondByte;
              end
            end
          end
          ST_AACK: begin
            if (sclFall) begin
              if (shifter[0]) begin                               // RULE_01
                state <= ST_RBYT;
                bytesLeft <= `CTR_READ_BYTES;                     // RULE_02
                controlCode <= storedCode;                        // RULE_08
                shifter <= loadByte;
                sdaOut <= 1'b0;
                // a one bit is sent by releasing the line
                sdaOen_n <= loadByte[7];
                bitCnt <= 4'h1;
              end else begin
                state <= ST_WBYT;
                secondByte <= 1'b0;
                sdaOen_n <= 1'b1;
              end
            end
          end
          ST_WACK: begin
            if (sclFall) begin
              state <= ST_WBYT;
              sdaOen_n <= 1'b1;
            end
          end
          ST_RBYT: begin
            if (sclFall) begin
              if (bitCnt == `CTR_BYTE_BITS) begin
                state <= ST_RACK;
                sdaOen_n <= 1'b1;
                bytesLeft <= bytesLeft - 3'h1;
              end else begin
                shifter <= {shifter[6:0], 1'b0};
                sdaOen_n <= shifter[6];
                bitCnt <= bitCnt + 4'h1;
              end
            end
          end
          ST_RACK: begin
            if (sclRise) begin
              shifter[0] <= sda;
            end else if (sclFall) begin
              if (shifter[0] || bytesLeft == 3'h0) begin          // RULE_21
                state <= ST_IDLE;
              end else begin
                state <= ST_RBYT;
                shifter <= loadByte;
                sdaOut <= 1'b0;
                sdaOen_n <= loadByte[7];
                bitCnt <= 4'h1;
              end
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end
endmodule

// File: rtl/ctr_sync.v
// two-flop synchroniser for pins from outside the clock domain
// assumes clk is the block clock, resetn async active low
module ctr_sync (
  // clock and reset
  input  wire clk,
  input  wire resetn,
  // pin in, synchronised out
  input  wire async,
  output reg  sync
);
  reg stage;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stage <= 1'b1;
      sync  <= 1'b1;
    end else begin
      stage <= async;
      sync  <= stage;
    end
  end
endmodule
